// *** sysctl_pkg.sv ***
package sysctl_pkg;
	localparam logic [31:0] ADDR_CONTROL = 32'h01f8_0000;
	localparam logic [31:0] ADDR_SW_RESET = 32'h01f8_0004;
	localparam logic [31:0] ADDR_POWER_DOWN = 32'h01f8_0008;
	localparam logic [31:0] ADDR_MEM_CONFIG = 32'h01f8_0010;
	// control register fields
	localparam int CTL_SCALER_LSB = 24;
	localparam int CTL_CLK_SEL_BIT = 23;
	localparam int CTL_RATE_DOUBLE_BIT = 22;
	localparam int CTL_SWRST_EN_BIT = 1;
	localparam int CTL_PWRDN_EN_BIT = 0;
	localparam logic [7:0] SCALER_RESET = 8'h01;
	localparam logic CLK_SEL_RESET = 1'b1;
	// memory configuration fields
	localparam int MC_COUNT_LSB = 0;
	localparam int MC_SP0_EN_BIT = 2;
	localparam int MC_SP0_TGT_LSB = 3;
	localparam int MC_SP1_EN_BIT = 6;
	localparam int MC_SP1_TGT_LSB = 7;
	localparam int MC_WIDTH = 10;
	localparam logic [MC_WIDTH-1:0] MC_RESET = 10'h000;
	localparam int SYSRST_PULSE_CYCLES = 4;
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;
endpackage

// *** sysctl_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module sysctl_regs (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire sysctl_pkg::bus_req_t bus_req,
	output logic [31:0] rdata,
	input wire logic watchdog_clock_in,
	input wire logic [7:0] ram_select_req,
	output logic [9:0] ram_chip_select,
	output logic serial_clk_en,
	output logic serial_rate_double,
	output logic sys_reset_out,
	output logic power_down
);
	import sysctl_pkg::*;

	logic [7:0] scaler_q;
	logic clk_sel_q, rate_dbl_q, swrst_en_q, pwrdn_en_q;
	logic [MC_WIDTH-1:0] mc_q;
	logic [2:0] rst_cnt_q;
	logic wd_s1_q, wd_s2_q, wd_s3_q;
	logic [7:0] div_q;
	logic [7:0] enabled;
	logic sp0_en, sp1_en;
	logic [2:0] sp0_tgt, sp1_tgt;
	logic tick;

	assign serial_rate_double = rate_dbl_q;
	assign sp0_en = mc_q[MC_SP0_EN_BIT];
	assign sp1_en = mc_q[MC_SP1_EN_BIT];
	assign sp0_tgt = mc_q[MC_SP0_TGT_LSB +: 3];
	assign sp1_tgt = mc_q[MC_SP1_TGT_LSB +: 3];

	// control register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			scaler_q <= SCALER_RESET;
			clk_sel_q <= CLK_SEL_RESET;
			rate_dbl_q <= 1'b0;
			swrst_en_q <= 1'b0;
			pwrdn_en_q <= 1'b0;
		end else if (bus_req.wr && bus_req.addr == ADDR_CONTROL) begin
			scaler_q <= bus_req.wdata[CTL_SCALER_LSB +: 8];
			clk_sel_q <= bus_req.wdata[CTL_CLK_SEL_BIT];
			rate_dbl_q <= bus_req.wdata[CTL_RATE_DOUBLE_BIT];
			swrst_en_q <= bus_req.wdata[CTL_SWRST_EN_BIT];
			pwrdn_en_q <= bus_req.wdata[CTL_PWRDN_EN_BIT];
		end
	end

	// memory configuration register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			mc_q <= MC_RESET;
		end else if (bus_req.wr && bus_req.addr == ADDR_MEM_CONFIG) begin
			mc_q <= bus_req.wdata[MC_WIDTH-1:0];
		end
	end

	// read data, one cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rdata <= 32'h0000_0000;
		end else if (bus_req.rd && bus_req.addr == ADDR_CONTROL) begin
			rdata <= {scaler_q, clk_sel_q, rate_dbl_q, 20'h00000, swrst_en_q, pwrdn_en_q};
		end else if (bus_req.rd && bus_req.addr == ADDR_MEM_CONFIG) begin
			rdata <= {22'h000000, mc_q};
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	// software reset pulse generator
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rst_cnt_q <= 3'h0;
		end else if (bus_req.wr && bus_req.addr == ADDR_SW_RESET && swrst_en_q) begin
			rst_cnt_q <= 3'(SYSRST_PULSE_CYCLES);
		end else if (rst_cnt_q != 3'h0) begin
			rst_cnt_q <= rst_cnt_q - 3'h1;
		end
	end
	assign sys_reset_out = (rst_cnt_q != 3'h0);

	// power-down entry, left by reset
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			power_down <= 1'b0;
		end else if (bus_req.wr && bus_req.addr == ADDR_POWER_DOWN && pwrdn_en_q) begin
			power_down <= 1'b1;
		end
	end

	// watchdog clock synchroniser and rising edge
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wd_s1_q <= 1'b0;
			wd_s2_q <= 1'b0;
			wd_s3_q <= 1'b0;
		end else begin
			wd_s1_q <= watchdog_clock_in;
			wd_s2_q <= wd_s1_q;
			wd_s3_q <= wd_s2_q;
		end
	end
	assign tick = clk_sel_q ? 1'b1 : (wd_s2_q && !wd_s3_q);

	// scaler divider: divide by scaler+1, stopped at zero
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			div_q <= 8'h00;
			serial_clk_en <= 1'b0;
		end else if (scaler_q == 8'h00) begin
			div_q <= 8'h00;
			serial_clk_en <= 1'b0;
		end else if (tick) begin
			serial_clk_en <= (div_q == 8'h00);
			div_q <= (div_q == 8'h00) ? scaler_q : div_q - 8'h01;
		end else begin
			serial_clk_en <= 1'b0;
		end
	end

	// chip select enables from block count
	always_comb begin
		unique case (mc_q[MC_COUNT_LSB +: 2])
			2'b00: enabled = 8'h01;
			2'b01: enabled = 8'h03;
			2'b10: enabled = 8'h0f;
			2'b11: enabled = 8'hff;
		endcase
	end

	// chip select remapping, combinational so timing matches
	always_comb begin
		ram_chip_select = {2'b00, ram_select_req & enabled};
		if (sp0_en) begin
			ram_chip_select[sp0_tgt] = 1'b0;
			ram_chip_select[8] = ram_select_req[sp0_tgt] & enabled[sp0_tgt];
		end
		if (sp1_en && !(sp0_en && sp0_tgt == sp1_tgt)) begin
			ram_chip_select[sp1_tgt] = 1'b0;
			ram_chip_select[9] = ram_select_req[sp1_tgt] & enabled[sp1_tgt];
		end
	end

	// trigger strobes and control writes, named once for the checks below
	logic swrst_fire;
	logic pwrdn_fire;
	logic ctl_write;
	assign swrst_fire = bus_req.wr && bus_req.addr == ADDR_SW_RESET && swrst_en_q;
	assign pwrdn_fire = bus_req.wr && bus_req.addr == ADDR_POWER_DOWN && pwrdn_en_q;
	assign ctl_write = bus_req.wr && bus_req.addr == ADDR_CONTROL;

	// reset pulse steps: enabled write, pulse, four cycles without a new write
	sequence seq_swrst_fire;
		swrst_fire;
	endsequence

	sequence seq_swrst_pulse;
		sys_reset_out [*4];
	endsequence

	sequence seq_swrst_quiet;
		!swrst_fire [*4];
	endsequence

	// scaler comes out of reset as one
	AST_SCALER_RESET: assert property (@(posedge core_clk)
		$rose(rst_n) |-> scaler_q == SCALER_RESET)
		else $error("scaler reset wrong");

	// other state comes out of reset cleared, system clock selected
	AST_RESET_VALUES: assert property (@(posedge core_clk)
		$rose(rst_n) |-> mc_q == MC_RESET && !power_down && !sys_reset_out && clk_sel_q
		&& rdata == 32'h0000_0000)
		else $error("reset values wrong");

	// zero scaler keeps the serial clock stopped
	AST_STOP_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
		scaler_q == 8'h00 |=> !serial_clk_en)
		else $error("serial clock not stopped");

	// scaler one on the system clock gives every second cycle
	AST_SYSTEM_CLOCK_IN_DIV: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_sel_q && scaler_q == 8'h01 && $stable(scaler_q) && !ctl_write && serial_clk_en
		|=> !serial_clk_en ##1 serial_clk_en)
		else $error("divide by two wrong");

	// watchdog source: no serial tick without a synced watchdog edge
	AST_WD_GATE: assert property (@(posedge core_clk) disable iff (!rst_n)
		!clk_sel_q && scaler_q != 8'h00 && !(wd_s2_q && !wd_s3_q) |=> !serial_clk_en)
		else $error("tick without watchdog edge");

	// enabled trigger write gives four reset cycles
	AST_SWRST: assert property (@(posedge core_clk) disable iff (!rst_n)
		seq_swrst_fire |=> seq_swrst_pulse)
		else $error("reset not issued");

	// pulse ends after four cycles when not written again
	AST_SWRST_END: assert property (@(posedge core_clk) disable iff (!rst_n)
		seq_swrst_fire ##1 seq_swrst_quiet |=> !sys_reset_out)
		else $error("reset pulse too long");

	// no reset output without an enabled trigger write
	AST_SWRST_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
		!sys_reset_out && !swrst_fire |=> !sys_reset_out)
		else $error("spurious reset");

	// trigger write with the function disabled does nothing
	AST_SWRST_DIS: assert property (@(posedge core_clk) disable iff (!rst_n)
		bus_req.wr && bus_req.addr == ADDR_SW_RESET && !swrst_en_q && !sys_reset_out
		|=> !sys_reset_out)
		else $error("disabled reset acted");

	// trigger address reads back zero
	AST_READ_TRIGGER: assert property (@(posedge core_clk) disable iff (!rst_n)
		bus_req.rd && bus_req.addr == ADDR_SW_RESET |=> rdata == 32'h0000_0000)
		else $error("trigger read not zero");

	// enabled power-down write enters power-down
	AST_PWRDN: assert property (@(posedge core_clk) disable iff (!rst_n)
		pwrdn_fire |=> power_down)
		else $error("power down missed");

	// power-down is only left by reset
	AST_PWRDN_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
		power_down |=> power_down)
		else $error("power down left");

	// no power-down without an enabled trigger write
	AST_PWRDN_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
		!power_down && !pwrdn_fire |=> !power_down)
		else $error("spurious power down");

	// power-down write with the function disabled does nothing
	AST_PWRDN_DIS: assert property (@(posedge core_clk) disable iff (!rst_n)
		bus_req.wr && bus_req.addr == ADDR_POWER_DOWN && !pwrdn_en_q && !power_down
		|=> !power_down)
		else $error("disabled power down acted");

	// without spares the selects follow request and block count
	AST_COUNT: assert property (@(posedge core_clk) disable iff (!rst_n)
		!sp0_en && !sp1_en |-> ram_chip_select == {2'b00, ram_select_req & enabled})
		else $error("chip select count wrong");

	// count 00: selects 7..1 stay off
	AST_COUNT_ONE: assert property (@(posedge core_clk) disable iff (!rst_n)
		mc_q[MC_COUNT_LSB +: 2] == 2'b00 |-> ram_chip_select[7:1] == 7'h00)
		else $error("select above 0 active");

	// count 01: selects 7..2 stay off
	AST_COUNT_TWO: assert property (@(posedge core_clk) disable iff (!rst_n)
		mc_q[MC_COUNT_LSB +: 2] == 2'b01 |-> ram_chip_select[7:2] == 6'h00)
		else $error("select above 1 active");

	// count 10: selects 7..4 stay off
	AST_COUNT_FOUR: assert property (@(posedge core_clk) disable iff (!rst_n)
		mc_q[MC_COUNT_LSB +: 2] == 2'b10 |-> ram_chip_select[7:4] == 4'h0)
		else $error("select above 3 active");

	// read back of the memory configuration
	AST_READ_MC: assert property (@(posedge core_clk) disable iff (!rst_n)
		bus_req.rd && bus_req.addr == ADDR_MEM_CONFIG
		|=> rdata == {22'h000000, $past(mc_q)})
		else $error("memory configuration read wrong");

	// first spare: target off, select 8 carries its request
	AST_SPARE0: assert property (@(posedge core_clk) disable iff (!rst_n)
		sp0_en |-> !ram_chip_select[sp0_tgt] &&
		ram_chip_select[8] == (ram_select_req[sp0_tgt] & enabled[sp0_tgt]))
		else $error("spare 8 wrong");

	// target code names the select index directly
	AST_SPARE0_MAP: assert property (@(posedge core_clk) disable iff (!rst_n)
		sp0_en && mc_q[MC_COUNT_LSB +: 2] == 2'b11 && ram_select_req == (8'h01 << sp0_tgt)
		|-> ram_chip_select == 10'h100)
		else $error("spare target index wrong");

	// second spare: target off, select 9 carries its request
	AST_SPARE1: assert property (@(posedge core_clk) disable iff (!rst_n)
		sp1_en && !(sp0_en && sp0_tgt == sp1_tgt) |-> !ram_chip_select[sp1_tgt] &&
		ram_chip_select[9] == (ram_select_req[sp1_tgt] & enabled[sp1_tgt]))
		else $error("spare 9 wrong");

	// equal targets: second spare stays out
	AST_SPARE1_SAME: assert property (@(posedge core_clk) disable iff (!rst_n)
		sp0_en && sp1_en && sp0_tgt == sp1_tgt |-> !ram_chip_select[9])
		else $error("second spare not ignored");

	// spare 8 silent while its enable is clear
	AST_NO_SPARE: assert property (@(posedge core_clk) disable iff (!rst_n)
		!sp0_en |-> !ram_chip_select[8])
		else $error("spare 8 without enable");

	// spare 9 silent while its enable is clear
	AST_NO_SPARE1: assert property (@(posedge core_clk) disable iff (!rst_n)
		!sp1_en |-> !ram_chip_select[9])
		else $error("spare 9 without enable");

	// spare fires in the same cycle as the replaced request
	AST_SPARE_TIMING: assert property (@(posedge core_clk) disable iff (!rst_n)
		sp0_en && ram_select_req[sp0_tgt] && enabled[sp0_tgt] |-> ram_chip_select[8])
		else $error("spare 8 late");

	// second spare fires in the same cycle as the replaced request
	AST_SPARE1_TIMING: assert property (@(posedge core_clk) disable iff (!rst_n)
		sp1_en && !sp0_en && ram_select_req[sp1_tgt] && enabled[sp1_tgt]
		|-> ram_chip_select[9])
		else $error("spare 9 late");

endmodule // sysctl_regs
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import sysctl_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	bus_req_t req = '0;
	logic [7:0] sel = 8'h00;
	logic [31:0] rdata;
	logic [9:0] cs;
	logic wd, clk_en, dbl, srst, pd;
	logic [9:0] m;
	int miscompares = 0;
	int checked = 0;
	int n;
	always #25 core_clk = ~core_clk;
	wd_clock_src PART (.watchdog_clock_in(wd));
	sysctl_regs DUT (.core_clk(core_clk), .rst_n(rst_n), .bus_req(req), .rdata(rdata),
		.watchdog_clock_in(wd), .ram_select_req(sel), .ram_chip_select(cs),
		.serial_clk_en(clk_en), .serial_rate_double(dbl), .sys_reset_out(srst), .power_down(pd));
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge core_clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk) req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		@(posedge core_clk) req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk) req.rd <= 1'b0;
		@(negedge core_clk) chk("rdata", rdata, e);
	endtask
	// counts high cycles of the serial tick (w 0) or the reset output (w 1)
	task automatic cnt(input int k, input int w);
		n = 0;
		repeat (k) begin
			@(negedge core_clk);
			n += (w == 0) ? (clk_en === 1'b1) : (srst === 1'b1);
		end
	endtask
	// remapped chip selects from block count and spare settings
	function automatic logic [9:0] exp_cs(input logic [9:0] c, input logic [7:0] r);
		logic [7:0] o;
		logic [9:0] x;
		o = r & ((8'h01 << (8'h01 << c[1:0])) - 8'h01);
		x = {2'b00, o};
		if (c[2]) begin
			x[c[5:3]] = 1'b0;
			x[8] = o[c[5:3]];
		end
		if (c[6] && !(c[2] && c[9:7] == c[5:3])) begin
			x[c[9:7]] = 1'b0;
			x[9] = o[c[9:7]];
		end
		return x;
	endfunction
	task automatic give_verdict;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// cuts a hang short
	initial begin
		#100us;
		miscompares++;
		give_verdict();
	end
	initial begin
		void'($urandom(77330));
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(ADDR_CONTROL, 32'h0180_0000);
		rd(ADDR_MEM_CONFIG, 32'h0);
		rd(ADDR_SW_RESET, 32'h0);
		rd(32'h01f8_0020, 32'h0);
		$display("test reset values done");
		for (int i = 0; i < 48; i++) begin
			m = 10'($urandom);
			if (i % 4 == 0) m[9:7] = m[5:3];
			wr(ADDR_MEM_CONFIG, {22'h0, m});
			sel <= 8'h01 << $urandom_range(8);
			rd(ADDR_MEM_CONFIG, {22'h0, m});
			chk("chip_select", cs, exp_cs(m, sel));
		end
		$display("test chip select remap done");
		wr(ADDR_CONTROL, 32'h0480_0000); // scaler 4 for 62500 baud at 20 MHz
		repeat (3) @(negedge core_clk); // let the old divide phase run out
		cnt(50, 0);
		chk("tick_count", n, 10);
		wr(ADDR_CONTROL, 32'h0040_0000);
		repeat (3) @(negedge core_clk);
		cnt(50, 0);
		chk("tick_stopped", n, 0);
		chk("rate_double", dbl, 1'b1);
		wr(ADDR_CONTROL, 32'h0100_0000);
		cnt(200, 0);
		// about 19 watchdog edges in 200 cycles, halved by scaler one
		chk("watchdog_ticks", n >= 8 && n <= 10, 1'b1);
		$display("test serial scaler done");
		wr(ADDR_SW_RESET, $urandom);
		cnt(8, 1);
		chk("reset_disabled", n, 0);
		wr(ADDR_CONTROL, 32'h2);
		wr(ADDR_SW_RESET, $urandom);
		cnt(8, 1);
		chk("reset_pulse", n, SYSRST_PULSE_CYCLES);
		wr(ADDR_POWER_DOWN, $urandom);
		@(negedge core_clk) chk("pd_disabled", pd, 1'b0);
		wr(ADDR_CONTROL, 32'h1);
		wr(ADDR_POWER_DOWN, $urandom);
		rd(ADDR_POWER_DOWN, 32'h0);
		chk("pd_entered", pd, 1'b1);
		$display("test triggers done");
		give_verdict();
	end
endmodule // testbench
`default_nettype wire

// *** wd_clock_src.sv ***
`timescale 1ns/1ps
`default_nettype none
module wd_clock_src (
	output logic watchdog_clock_in
);
	initial watchdog_clock_in = 1'b0;
	// free-running watchdog clock, period unrelated to core_clk
	always #263 watchdog_clock_in = ~watchdog_clock_in;
endmodule // wd_clock_src
`default_nettype wire
